// ===== rtl/sii_map.vh
/*
 Constants for the status indicator and identification dial block: register
 offsets, field positions, reset values, state codes and pattern timing.
 Assumes a 125 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
// Operation
// - identification code equals tens dial times ten plus ones dial.
// - codes 01 to 159 become the explicit device identification value.
// - dials are captured once at startup; later changes wait for restart.
// - a reserved or invalid code keeps the previously valid identification.
// - readiness lamp is steady red when the dials were found invalid.
// - during startup refuse connections, lamp off; when ready, steady green.
// - readiness lamp flashes yellow while a firmware update runs.
// - supply, temperature or overload faults flash readiness green and yellow alternately.
// - state lamp off in Init, flashes at 2.5 Hz in Pre-Operational.
// - Safe-Operational gives a single pulse, 200 ms on, 1000 ms off.
// - state lamp is steady in Operational.
// - state lamp flashes at 10 Hz in Bootstrap.
// - fault lamp steady on critical error, off without error.
// - refused master state transition flashes fault lamp at 2.5 Hz.
// - fault lamp single pulse on application error, double on watchdog expiry.
// - sensor lamp green when power present, off when low, red on overload.
// - link lamp green while either bus port has a connection.
// - output lamp yellow when set, red when faulted; input lamp yellow when set.
// - channel lamps are numbered by process-data byte, then bit.
`ifndef SII_MAP_VH
`define SII_MAP_VH

// register byte offsets
`define SII_REG_CTRL 8'h00
`define SII_REG_FAULT 8'h04
`define SII_REG_CHAN 8'h08
`define SII_REG_IDSTORE 8'h0C
`define SII_REG_STATUS 8'h10

// control fields
`define SII_CTRL_READY 0
`define SII_CTRL_UPDATE 1
`define SII_CTRL_STATE_LO 8
`define SII_CTRL_STATE_HI 11

// fault fields
`define SII_FLT_CRIT 0
`define SII_FLT_CFG 1
`define SII_FLT_APP 2
`define SII_FLT_WDOG 3
`define SII_FLT_SNS_VOLT 8
`define SII_FLT_TEMP 9
`define SII_FLT_DRV_FAIL 10
`define SII_FLT_DRV_SURGE 11
`define SII_FLT_SNS_OVL 12
`define SII_FLT_SNS_PRES 16
`define SII_FLT_DRV_PRES 17

// reset values
`define SII_CTRL_RST 32'h00000000
`define SII_FAULT_RST 32'h00000000
`define SII_CHAN_RST 32'h00000000
`define SII_IDSTORE_RST 8'h00

// fieldbus state codes in the state field
`define SII_ST_INIT 4'h1
`define SII_ST_PREOP 4'h2
`define SII_ST_BOOT 4'h3
`define SII_ST_SAFEOP 4'h4
`define SII_ST_OP 4'h8

// identification code range
`define SII_ID_MIN 8'h01
`define SII_ID_MAX 8'h9F
`define SII_ONES_MAX 4'h9
`define SII_SETTLE_CYC 3'h7

// timing: clock in kHz gives cycles per millisecond
`define SII_CLK_KHZ 125000
`define SII_SLOW_FREQ_DHZ 25
`define SII_FAST_FREQ_DHZ 100
`define SII_SLOW_HALF_MS (5000 / `SII_SLOW_FREQ_DHZ)
`define SII_FAST_HALF_MS (5000 / `SII_FAST_FREQ_DHZ)
`define SII_PULSE_ON_MS 200
`define SII_PULSE_OFF_MS 1000
`define SII_SINGLE_PERIOD_MS (`SII_PULSE_ON_MS + `SII_PULSE_OFF_MS)
`define SII_DOUBLE_PERIOD_MS (3 * `SII_PULSE_ON_MS + `SII_PULSE_OFF_MS)

// bus responses
`define SII_RESP_OKAY 2'b00
`define SII_RESP_SLVERR 2'b10

`endif

// ===== rtl/sii_sync.v
/*
 Three-stage input synchroniser for pins from outside the clock domain.
 The output follows only when the second and third stages agree, so a
 single-cycle glitch never reaches the logic. Assumes aclk is free running.
*/
`timescale 1ns/100ps
module sii_sync #(
    parameter W = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] sync_out
);

reg [W-1:0] s1_ff;
reg [W-1:0] s2_ff;
reg [W-1:0] s3_ff;

// first stage feeds only the second stage
always @(posedge aclk) begin
    if (!aresetn) begin
        s1_ff <= {W{1'b0}};
        s2_ff <= {W{1'b0}};
        s3_ff <= {W{1'b0}};
        sync_out <= {W{1'b0}};
    end else begin
        s1_ff <= pin_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
            sync_out <= s3_ff;
        end
    end
end

endmodule // sii_sync

// ===== rtl/sii_top.v
/*
 Status indicator and identification dial logic. Captures the two dials once
 after reset, forms the identification value, and drives every front-panel
 lamp from register state written by firmware, from the dial check and from link pins.
 Assumes an AXI4-Lite master with one write and one read outstanding, and
 firmware that restores the last valid identification into the id store.
*/
`timescale 1ns/100ps
`include "sii_map.vh"
module sii_top #(
    parameter MS_CYC = `SII_CLK_KHZ
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] tens_dial,
    input wire [3:0] ones_dial,
    input wire upstream_bus_port_link,
    input wire downstream_bus_port_link,
    output reg [7:0] dev_id,
    output reg dev_id_valid,
    output reg conn_enable,
    output reg ready_lamp_green,
    output reg ready_lamp_yellow,
    output reg ready_lamp_red,
    output reg state_lamp,
    output reg fault_lamp,
    output reg sensor_supply_lamp_green,
    output reg sensor_supply_lamp_red,
    output reg drive_power_lamp,
    output reg link_lamp,
    output reg [7:0] in_lamp_byte0,
    output reg [7:0] out_lamp_byte0_yellow,
    output reg [7:0] out_lamp_byte0_red
);
// pattern limits kept at full integer width; compares widen the counters
localparam [31:0] MS_LAST = MS_CYC - 1;
localparam [31:0] SLOW_LAST = `SII_SLOW_HALF_MS - 1;
localparam [31:0] FAST_LAST = `SII_FAST_HALF_MS - 1;
localparam [31:0] PULSE_ON = `SII_PULSE_ON_MS;
localparam [31:0] SINGLE_LAST = `SII_SINGLE_PERIOD_MS - 1;
localparam [31:0] DOUBLE_LAST = `SII_DOUBLE_PERIOD_MS - 1;
wire [7:0] dial_sync;
wire [1:0] link_sync;
sii_sync #(.W(8)) u_dial_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({tens_dial, ones_dial}),
    .sync_out(dial_sync)
);
sii_sync #(.W(2)) u_link_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({upstream_bus_port_link, downstream_bus_port_link}),
    .sync_out(link_sync)
);
// register bus slave
reg aw_got_ff, w_got_ff, rd_hit;
reg [7:0] awaddr_ff, idstore_ff;
reg [3:0] wstrb_ff;
reg [31:0] wdata_ff, ctrl_ff, fault_ff, chan_ff, nxt_wreg, wold, rd_mux;
wire wr_fire;
integer bi;
// new address or data only while no response is pending
assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
assign s_axi_wready = ~w_got_ff & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
// byte-lane merge of the stored write onto the addressed register
always @* begin
    case (awaddr_ff)
        `SII_REG_CTRL: wold = ctrl_ff;
        `SII_REG_FAULT: wold = fault_ff;
        `SII_REG_CHAN: wold = chan_ff;
        `SII_REG_IDSTORE: wold = {24'h000000, idstore_ff};
        default: wold = 32'h00000000;
    endcase
    nxt_wreg = wold;
    for (bi = 0; bi < 4; bi = bi + 1) begin
        if (wstrb_ff[bi]) begin
            nxt_wreg[bi*8 +: 8] = wdata_ff[bi*8 +: 8];
        end
    end
end
// address and data are taken in either order, then written together
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awaddr_ff <= 8'h00;
        wdata_ff <= 32'h00000000;
        wstrb_ff <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SII_RESP_OKAY;
        ctrl_ff <= `SII_CTRL_RST;
        fault_ff <= `SII_FAULT_RST;
        chan_ff <= `SII_CHAN_RST;
        idstore_ff <= `SII_IDSTORE_RST;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `SII_RESP_OKAY;
            case (awaddr_ff)
                `SII_REG_CTRL: ctrl_ff <= nxt_wreg;
                `SII_REG_FAULT: fault_ff <= nxt_wreg;
                `SII_REG_CHAN: chan_ff <= nxt_wreg;
                `SII_REG_IDSTORE: idstore_ff <= nxt_wreg[7:0];
                // status is read-only, so a write there is refused as well
                default: s_axi_bresp <= `SII_RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end
// identification capture
reg [2:0] settle_ff;
reg captured_ff, dial_bad_ff;
reg [7:0] dial_code_ff;
wire [3:0] tens_s, ones_s;
wire [7:0] code_now;
wire code_ok;
assign tens_s = dial_sync[7:4];
assign ones_s = dial_sync[3:0];
assign code_now = {1'b0, tens_s, 3'b000} + {3'b000, tens_s, 1'b0} + {4'h0, ones_s};
assign code_ok = (ones_s <= `SII_ONES_MAX) && (code_now >= `SII_ID_MIN)
    && (code_now <= `SII_ID_MAX);
// sampling waits until the synchroniser has filled with the dial level
always @(posedge aclk) begin
    if (!aresetn) begin
        settle_ff <= 3'h0;
        captured_ff <= 1'b0;
        dial_bad_ff <= 1'b0;
        dial_code_ff <= 8'h00;
    end else if (!captured_ff) begin
        if (settle_ff == `SII_SETTLE_CYC) begin
            captured_ff <= 1'b1;
            dial_code_ff <= code_now;
            dial_bad_ff <= ~code_ok;
        end else begin
            settle_ff <= settle_ff + 3'h1;
        end
    end
end
always @(posedge aclk) begin
    if (!aresetn) begin
        dev_id <= 8'h00;
        dev_id_valid <= 1'b0;
    end else begin
        dev_id <= dial_bad_ff ? idstore_ff : dial_code_ff;
        dev_id_valid <= captured_ff;
    end
end
// read mux; status shows the block's own capture result
always @* begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
        `SII_REG_CTRL: rd_mux = ctrl_ff;
        `SII_REG_FAULT: rd_mux = fault_ff;
        `SII_REG_CHAN: rd_mux = chan_ff;
        `SII_REG_IDSTORE: rd_mux = {24'h000000, idstore_ff};
        `SII_REG_STATUS: rd_mux = {11'h000, link_lamp, dial_code_ff, 2'b00,
            captured_ff, dial_bad_ff, dev_id};
        default: begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
        end
    endcase
end

// read answer one cycle after the address is taken
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `SII_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `SII_RESP_OKAY : `SII_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end
// pattern timebase: one millisecond tick, then small counters in ms
reg [31:0] ms_cnt_ff;
reg [10:0] slow_cnt_ff, fast_cnt_ff, single_cnt_ff, double_cnt_ff;
reg ms_tick_ff, slow_ph_ff, fast_ph_ff;
wire single_on, double_on;
always @(posedge aclk) begin
    if (!aresetn) begin
        ms_cnt_ff <= 32'h00000000;
        ms_tick_ff <= 1'b0;
    end else begin
        ms_tick_ff <= (ms_cnt_ff == MS_LAST);
        ms_cnt_ff <= (ms_cnt_ff == MS_LAST) ? 32'h00000000 : ms_cnt_ff + 32'h00000001;
    end
end

// equal halves give 50 percent flashing
always @(posedge aclk) begin
    if (!aresetn) begin
        slow_cnt_ff <= 11'h000;
        fast_cnt_ff <= 11'h000;
        single_cnt_ff <= 11'h000;
        double_cnt_ff <= 11'h000;
        slow_ph_ff <= 1'b0;
        fast_ph_ff <= 1'b0;
    end else if (ms_tick_ff) begin
        slow_cnt_ff <= (slow_cnt_ff == SLOW_LAST) ? 11'h000 : slow_cnt_ff + 11'h001;
        fast_cnt_ff <= (fast_cnt_ff == FAST_LAST) ? 11'h000 : fast_cnt_ff + 11'h001;
        single_cnt_ff <= (single_cnt_ff == SINGLE_LAST) ? 11'h000 : single_cnt_ff + 11'h001;
        double_cnt_ff <= (double_cnt_ff == DOUBLE_LAST) ? 11'h000 : double_cnt_ff + 11'h001;
        if (slow_cnt_ff == SLOW_LAST) begin
            slow_ph_ff <= ~slow_ph_ff;
        end
        if (fast_cnt_ff == FAST_LAST) begin
            fast_ph_ff <= ~fast_ph_ff;
        end
    end
end
// 200 ms on then 1000 ms off
assign single_on = (single_cnt_ff < PULSE_ON);
// two pulses separated by an equal gap
assign double_on = (double_cnt_ff < PULSE_ON)
    || ((double_cnt_ff >= 2 * PULSE_ON) && (double_cnt_ff < 3 * PULSE_ON));
// lamp decode from register state
wire fw_ready, fw_update, supply_alarm;
wire [3:0] run_state;
reg nxt_green, nxt_yellow, nxt_red, nxt_state, nxt_fault;
assign fw_ready = ctrl_ff[`SII_CTRL_READY];
assign fw_update = ctrl_ff[`SII_CTRL_UPDATE];
assign run_state = ctrl_ff[`SII_CTRL_STATE_HI:`SII_CTRL_STATE_LO];
assign supply_alarm = fault_ff[`SII_FLT_SNS_VOLT] | fault_ff[`SII_FLT_TEMP]
    | fault_ff[`SII_FLT_DRV_FAIL] | fault_ff[`SII_FLT_DRV_SURGE]
    | fault_ff[`SII_FLT_SNS_OVL];

// readiness priority: dial fault, startup, update, supply alarm, ready
always @* begin
    nxt_green = 1'b0;
    nxt_yellow = 1'b0;
    nxt_red = 1'b0;
    if (dial_bad_ff) begin
        nxt_red = 1'b1;
    end else if (!fw_ready) begin
        nxt_green = 1'b0;
    end else if (fw_update) begin
        nxt_yellow = slow_ph_ff;
    end else if (supply_alarm) begin
        nxt_green = slow_ph_ff;
        nxt_yellow = ~slow_ph_ff;
    end else begin
        nxt_green = 1'b1;
    end
end

// state lamp follows the fieldbus state machine code
always @* begin
    case (run_state)
        `SII_ST_INIT: nxt_state = 1'b0;
        `SII_ST_PREOP: nxt_state = slow_ph_ff;
        `SII_ST_SAFEOP: nxt_state = single_on;
        `SII_ST_OP: nxt_state = 1'b1;
        `SII_ST_BOOT: nxt_state = fast_ph_ff;
        default: nxt_state = 1'b0;
    endcase
end

// fault lamp: the most severe error shown alone
always @* begin
    if (fault_ff[`SII_FLT_CRIT]) begin
        nxt_fault = 1'b1;
    end else if (fault_ff[`SII_FLT_WDOG]) begin
        nxt_fault = double_on;
    end else if (fault_ff[`SII_FLT_CFG]) begin
        nxt_fault = slow_ph_ff;
    end else if (fault_ff[`SII_FLT_APP]) begin
        nxt_fault = single_on;
    end else begin
        nxt_fault = 1'b0;
    end
end

// all lamps registered so that no decode glitch reaches a pin
always @(posedge aclk) begin
    if (!aresetn) begin
        conn_enable <= 1'b0;
        ready_lamp_green <= 1'b0;
        ready_lamp_yellow <= 1'b0;
        ready_lamp_red <= 1'b0;
        state_lamp <= 1'b0;
        fault_lamp <= 1'b0;
        sensor_supply_lamp_green <= 1'b0;
        sensor_supply_lamp_red <= 1'b0;
        drive_power_lamp <= 1'b0;
        link_lamp <= 1'b0;
        in_lamp_byte0 <= 8'h00;
        out_lamp_byte0_yellow <= 8'h00;
        out_lamp_byte0_red <= 8'h00;
    end else begin
        conn_enable <= fw_ready & captured_ff;
        ready_lamp_green <= nxt_green;
        ready_lamp_yellow <= nxt_yellow;
        ready_lamp_red <= nxt_red;
        state_lamp <= nxt_state;
        fault_lamp <= nxt_fault;
        // overload red, else green when present
        sensor_supply_lamp_red <= fault_ff[`SII_FLT_SNS_OVL];
        sensor_supply_lamp_green <= fault_ff[`SII_FLT_SNS_PRES] & ~fault_ff[`SII_FLT_SNS_OVL];
        drive_power_lamp <= fault_ff[`SII_FLT_DRV_PRES];
        link_lamp <= link_sync[1] | link_sync[0];
        // byte 0, bit index per lamp
        in_lamp_byte0 <= chan_ff[23:16];
        out_lamp_byte0_yellow <= chan_ff[7:0] & ~chan_ff[15:8];
        out_lamp_byte0_red <= chan_ff[15:8];
    end
end

endmodule // sii_top

// ===== tb/sii_panel.sv
/*
 Operator panel model: the two coding dials and the two bus cables.
 Assumes the bench calls its tasks from a clocked sequence on aclk.
*/
`timescale 1ns/100ps
module sii_panel (
    input wire aclk,
    output logic [3:0] tens_dial,
    output logic [3:0] ones_dial,
    output logic upstream_bus_port_link,
    output logic downstream_bus_port_link
);
    // dials at zero and both cables pulled at power-up
    initial begin
        tens_dial = 4'h0;
        ones_dial = 4'h0;
        upstream_bus_port_link = 1'b0;
        downstream_bus_port_link = 1'b0;
    end
    task automatic turn(input logic [3:0] t, input logic [3:0] o);
        @(posedge aclk);
        tens_dial <= t;
        ones_dial <= o;
    endtask
    // a cable is plugged or pulled just after an edge
    task automatic plug(input logic up, input logic dn);
        @(posedge aclk);
        upstream_bus_port_link <= up;
        downstream_bus_port_link <= dn;
    endtask
endmodule // sii_panel

// ===== tb/sii_top_chk.sv
/*
 Port checker for sii_top: id, readiness, link and channel lamp relations.
 Assumes it is bound onto sii_top; aresetn is synchronous, active low.
*/
`timescale 1ns/100ps
module sii_top_chk (
    input wire aclk,
    input wire aresetn,
    input wire upstream_bus_port_link,
    input wire downstream_bus_port_link,
    input wire [7:0] dev_id,
    input wire dev_id_valid,
    input wire conn_enable,
    input wire ready_lamp_green,
    input wire ready_lamp_yellow,
    input wire ready_lamp_red,
    input wire sensor_supply_lamp_green,
    input wire sensor_supply_lamp_red,
    input wire link_lamp,
    input wire [7:0] out_lamp_byte0_yellow,
    input wire [7:0] out_lamp_byte0_red
);
    // eight cycles cover the pin synchroniser plus the lamp register
    wire any_link = upstream_bus_port_link | downstream_bus_port_link;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // startup and identification
    conn_id_a: assert property (!dev_id_valid |-> !conn_enable && !ready_lamp_green)
        else $error("connection or green before capture");
    capture_once_a: assert property (dev_id_valid |=> dev_id_valid)
        else $error("capture flag dropped");
    id_steady_a: assert property (dev_id_valid && !ready_lamp_red |=> $stable(dev_id))
        else $error("dev_id moved while running");
    id_range_a: assert property (dev_id_valid && !ready_lamp_red
        |-> dev_id != 8'h00 && dev_id <= 8'h9F)
        else $error("dev_id outside code range");
    // lamps
    red_only_a: assert property (ready_lamp_red
        |-> !ready_lamp_green && !ready_lamp_yellow)
        else $error("red readiness not exclusive");
    link_on_a: assert property (any_link [*8] |-> link_lamp)
        else $error("link lamp off with cable");
    link_off_a: assert property (!any_link [*8] |-> !link_lamp)
        else $error("link lamp on without cable");
    sensor_excl_a: assert property (sensor_supply_lamp_red |-> !sensor_supply_lamp_green)
        else $error("sensor lamp red and green");
    chan_excl_a: assert property ((out_lamp_byte0_yellow & out_lamp_byte0_red) == 8'h00)
        else $error("output lamp yellow and red");
endmodule // sii_top_chk

// ===== tb/sii_top_tb.sv
/*
 Bench for sii_top: AXI4-Lite tasks, dial restarts and lamp pattern counts.
 Assumes MS_CYC of 10, so one slow half period is 2000 cycles.
*/
`timescale 1ns/100ps
`include "sii_map.vh"
module sii_top_tb;
    localparam int MS = 10;
    localparam int T = 200 * MS;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] tens_dial, ones_dial;
    wire upstream_bus_port_link, downstream_bus_port_link, dev_id_valid, conn_enable;
    wire ready_lamp_green, ready_lamp_yellow, ready_lamp_red, state_lamp, fault_lamp;
    wire sensor_supply_lamp_green, sensor_supply_lamp_red, drive_power_lamp, link_lamp;
    wire [7:0] dev_id, in_lamp_byte0, out_lamp_byte0_yellow, out_lamp_byte0_red;
    int errors, check_count;
    int cnt [4];
    logic [3:0] st [5] = '{`SII_ST_INIT, `SII_ST_PREOP, `SII_ST_BOOT, `SII_ST_SAFEOP, `SII_ST_OP};
    logic [3:0] flt [5] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'hC};
    int win [5] = '{2 * T, 2 * T, 2 * T, 6 * T, 8 * T};
    int st_exp [5] = '{0, T, T, T, 8 * T};
    int fl_exp [5] = '{0, T, 2 * T, T, 2 * T};

    sii_top #(.MS_CYC(MS)) u_sii_top (.*);
    sii_panel u_panel (.*);

    // free-running 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // hang guard, well beyond the pattern windows
    initial begin
        repeat (90000) @(posedge aclk);
        errors++;
        $display("mismatch watchdog expected finish seen hang");
        complete_run();
    end

    task automatic complete_run;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // settle on the falling edge so registered outputs have landed
    task automatic gap(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    // address and data offered together, bready held high throughout
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ha, hw, hb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (hb !== 1'b1);
        chk("bresp", e, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic h;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            h = s_axi_arready;
            @(posedge aclk);
        end while (h !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            h = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (h !== 1'b1);
        chk("rdata", ed, d);
        chk("rresp", er, r);
    endtask
    // reset for 19 cycles with the dials set, then wait out the capture
    task automatic restart(input logic [3:0] t, input logic [3:0] o);
        @(posedge aclk);
        aresetn <= 1'b0;
        u_panel.turn(t, o);
        repeat (18) @(posedge aclk);
        aresetn <= 1'b1;
        gap(12);
    endtask
    // counts lamp-on cycles: state, fault, green, yellow
    task automatic meas(input int n);
        cnt = '{0, 0, 0, 0};
        repeat (n) begin
            @(negedge aclk);
            cnt[0] += state_lamp;
            cnt[1] += fault_lamp;
            cnt[2] += ready_lamp_green;
            cnt[3] += ready_lamp_yellow;
        end
    endtask

    // main sequence
    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        errors = 0;
        check_count = 0;
        restart(4'h7, 4'h7);
        chk("dev_id", 32'h4D, dev_id);
        chk("id_valid", 1, dev_id_valid);
        chk("startup", 0,
            {conn_enable, ready_lamp_green, ready_lamp_yellow, ready_lamp_red});
        for (int i = 0; i < 4; i++) rdc(8'(4 * i), 32'h0, `SII_RESP_OKAY);
        wr(`SII_REG_CTRL, 32'h00000101, `SII_RESP_OKAY);
        gap(2);
        chk("ready", 4'hC,
            {conn_enable, ready_lamp_green, ready_lamp_yellow, ready_lamp_red});
        rdc(`SII_REG_CTRL, 32'h00000101, `SII_RESP_OKAY);
        u_panel.turn(4'h1, 4'h2);
        gap(12);
        chk("dev_id held", 32'h4D, dev_id);
        rdc(`SII_REG_STATUS, 32'h0004D24D, `SII_RESP_OKAY);
        wr(`SII_REG_STATUS, 32'h0, `SII_RESP_SLVERR);
        rdc(8'h40, 32'h0, `SII_RESP_SLVERR);
        // each window spans whole periods, so counts are exact
        for (int i = 0; i < 5; i++) begin
            wr(`SII_REG_CTRL, {20'h0, st[i], 8'h01}, `SII_RESP_OKAY);
            wr(`SII_REG_FAULT, {28'h0, flt[i]}, `SII_RESP_OKAY);
            gap(4);
            meas(win[i]);
            chk("state_lamp", st_exp[i], cnt[0]);
            chk("fault_lamp", fl_exp[i], cnt[1]);
            chk("green", win[i], cnt[2]);
        end
        wr(`SII_REG_CTRL, {20'h0, `SII_ST_OP, 8'h03}, `SII_RESP_OKAY);
        wr(`SII_REG_FAULT, 32'h0, `SII_RESP_OKAY);
        gap(4);
        meas(2 * T);
        chk("update yellow", T, cnt[3]);
        chk("update green", 0, cnt[2]);
        wr(`SII_REG_CTRL, {20'h0, `SII_ST_OP, 8'h01}, `SII_RESP_OKAY);
        for (int b = 8; b < 13; b++) begin
            wr(`SII_REG_FAULT, 32'h1 << b, `SII_RESP_OKAY);
            gap(4);
            meas(2 * T);
            chk("alarm green", T, cnt[2]);
            chk("alarm yellow", T, cnt[3]);
        end
        wr(`SII_REG_FAULT, 32'h00030000, `SII_RESP_OKAY);
        gap(2);
        chk("supply", 3'b101,
            {sensor_supply_lamp_green, sensor_supply_lamp_red, drive_power_lamp});
        wr(`SII_REG_FAULT, 32'h00011000, `SII_RESP_OKAY);
        gap(2);
        chk("overload", 3'b010,
            {sensor_supply_lamp_green, sensor_supply_lamp_red, drive_power_lamp});
        wr(`SII_REG_CHAN, 32'h00A5030F, `SII_RESP_OKAY);
        gap(2);
        chk("chan", 24'hA50C03,
            {in_lamp_byte0, out_lamp_byte0_yellow, out_lamp_byte0_red});
        // only lane 2 may land, the other lanes keep their bytes
        @(posedge aclk) s_axi_wstrb <= 4'h4;
        wr(`SII_REG_CHAN, 32'hFF5AFFFF, `SII_RESP_OKAY);
        @(posedge aclk) s_axi_wstrb <= 4'hF;
        rdc(`SII_REG_CHAN, 32'h005A030F, `SII_RESP_OKAY);
        u_panel.plug(1'b1, 1'b0);
        gap(8);
        chk("link up", 1, link_lamp);
        u_panel.plug(1'b0, 1'b1);
        gap(8);
        chk("link down", 1, link_lamp);
        u_panel.plug(1'b0, 1'b0);
        gap(8);
        chk("link none", 0, link_lamp);
        restart(4'hF, 4'h9);
        chk("dev_id max", 32'h9F, dev_id);
        chk("red", 0, ready_lamp_red);
        restart(4'hF, 4'hA);
        chk("red ones", 1, ready_lamp_red);
        restart(4'h0, 4'h0);
        wr(`SII_REG_IDSTORE, 32'h9F, `SII_RESP_OKAY);
        wr(`SII_REG_CTRL, 32'h00000101, `SII_RESP_OKAY);
        gap(2);
        chk("kept id", 32'h9F, dev_id);
        chk("red wins", 3'b001,
            {ready_lamp_green, ready_lamp_yellow, ready_lamp_red});
        complete_run();
    end
endmodule // sii_top_tb

bind sii_top sii_top_chk u_sii_top_chk (.*);
